// ===== logic/alm_pkg.sv
// shared constants and carrier types for the alarm log and mute controller
package alm_pkg;

	// alarm log geometry
	localparam int LOG_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] LOG_FULL_CNT = 6'h20;
	localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 5'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;

	// entries handed out per read-next request
	localparam logic [2:0] READ_BURST = 3'h5;
	localparam logic [2:0] LEFT_RST = 3'h0;

	// gain reduction in quarter-dB steps over the documented range
	localparam int ATTEN_RANGE_DB = 30;
	localparam int ATTEN_STEPS_PER_DB = 4;
	localparam int ATTEN_W = 7;
	localparam logic [ATTEN_W-1:0] ATTEN_MAX = 7'(ATTEN_RANGE_DB * ATTEN_STEPS_PER_DB);
	localparam logic [ATTEN_W-1:0] ATTEN_RST = 7'h00;

	// date and time stamp, one byte per field
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] year;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} alm_stamp_t;

	typedef struct packed {
		alm_stamp_t stamp;
		logic [7:0] code;
	} alm_entry_t;

	localparam alm_entry_t ENTRY_RST = 56'h00_0000_0000_0000;

	// remote manager settings
	typedef struct packed {
		logic software_mute_ctl;
		logic bias_enable_ctl;
		logic discrete_mute_mode;
		logic [ATTEN_W-1:0] gain_reduction_ctl;
	} alm_mute_cfg_t;

	// amplifier stage drive
	typedef struct packed {
		logic low_stage_en;
		logic high_stage_en;
		logic muted;
		logic [ATTEN_W-1:0] atten_code;
	} alm_stage_t;

	localparam alm_stage_t STAGE_RST = 10'h000;

	typedef enum logic [1:0] {
		ALM_IDLE = 2'b01,
		ALM_SEND = 2'b10
	} alm_state_t;

endpackage

// ===== logic/alm_sync2.sv
// two-stage synchroniser for an asynchronous pin
`timescale 1ns/100ps
module alm_sync2 (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// pin and synchronised level
	input wire logic pin_async,
	output logic pin_sync
);
	logic stage1;
	logic next_stage1;
	logic next_pin_sync;

	always_comb begin
		next_stage1 = stage1;
		next_pin_sync = pin_sync;
		if (clk_en) begin
			next_stage1 = pin_async;
			next_pin_sync = stage1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			pin_sync <= next_pin_sync;
		end
	end
endmodule

// ===== logic/alm_stage_ctl.sv
// mute, bias and gain reduction combined into stage enables and attenuation code
`timescale 1ns/100ps
module alm_stage_ctl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// settings and synchronised discrete pin
	input alm_pkg::alm_mute_cfg_t cfg,
	input wire logic disc_pin_high,
	// stage drive
	output alm_pkg::alm_stage_t stage
);
	alm_pkg::alm_stage_t next_stage;
	logic mute_any;

	always_comb begin
		next_stage = stage;
		mute_any = cfg.software_mute_ctl | (cfg.discrete_mute_mode & disc_pin_high);
		if (clk_en) begin
			next_stage.muted = mute_any;
			next_stage.high_stage_en = !(cfg.software_mute_ctl && !cfg.bias_enable_ctl);
			next_stage.low_stage_en = !mute_any && next_stage.high_stage_en;
			next_stage.atten_code = (cfg.gain_reduction_ctl > alm_pkg::ATTEN_MAX) ?
				alm_pkg::ATTEN_MAX : cfg.gain_reduction_ctl;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= alm_pkg::STAGE_RST;
		end else begin
			stage <= next_stage;
		end
	end

	mute_keeps_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cfg.bias_enable_ctl |=> stage.high_stage_en)
		else $error("high stages dropped while amplifier enabled");

	// mute with amp off removes bias from both high and low stages
	bias_off_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cfg.software_mute_ctl && !cfg.bias_enable_ctl |=> !stage.high_stage_en
		&& !stage.low_stage_en)
		else $error("bias not removed for mute with amplifier off");

	sw_mute_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cfg.software_mute_ctl |=> stage.muted && !stage.low_stage_en)
		else $error("software mute did not mute");

	disc_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cfg.discrete_mute_mode && !cfg.software_mute_ctl && !disc_pin_high
		|=> !stage.muted)
		else $error("discrete mute not released by grounded pin");

	atten_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stage.atten_code <= alm_pkg::ATTEN_MAX)
		else $error("gain reduction beyond range");
endmodule

// ===== logic/alm_ctl.sv
// alarm log with five-entry readout, plus mute and bias control
// Functional notes
// - a read-next request hands out the oldest stored entries, five at most
// - entries are kept in arrival order with a date and time stamp
// - every entry handed out is removed from the log by that read
// - unread count falls with each read and reaches 00 when empty
// - clear-log removes every stored entry
// - pointer-initialize aborts any burst and leaves the read pointer at the oldest unread entry
// - software mute set to 1 mutes the amplifier
// - discrete mode keeps the unit muted until the pin is grounded
// - mute disables only low-power stages; high-power stages stay biased except with software mute 1 and enable 0
// - whole-amplifier bias goes only with mute 1 and enable 0
// - gain reduction spans a 30 dB range
`timescale 1ns/100ps
module alm_ctl (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// incoming alarms
	input wire logic alarm_valid,
	input wire logic [7:0] alarm_code,
	input alm_pkg::alm_stamp_t now_stamp,
	// manager requests, one-cycle pulses
	input wire logic cmd_read_next,
	input wire logic cmd_clear_log,
	input wire logic cmd_init_ptr,
	// manager settings
	input alm_pkg::alm_mute_cfg_t mute_cfg,
	// discrete mute pin, asynchronous
	input wire logic disc_ctl_pin,
	// log readout
	output logic out_valid,
	output alm_pkg::alm_entry_t out_entry,
	output logic out_last,
	// log status
	output logic [alm_pkg::CNT_W-1:0] unread_count,
	output logic log_full,
	output logic log_overflow,
	output logic read_busy,
	// amplifier stage drive
	output alm_pkg::alm_stage_t stage
);
	alm_pkg::alm_entry_t log_mem [alm_pkg::LOG_DEPTH];
	alm_pkg::alm_state_t state;
	alm_pkg::alm_state_t next_state;
	logic [alm_pkg::PTR_W-1:0] head;
	logic [alm_pkg::PTR_W-1:0] next_head;
	logic [alm_pkg::PTR_W-1:0] tail;
	logic [alm_pkg::PTR_W-1:0] next_tail;
	logic [alm_pkg::CNT_W-1:0] next_count;
	logic [2:0] left;
	logic [2:0] next_left;
	logic next_overflow;
	logic next_out_valid;
	logic next_out_last;
	alm_pkg::alm_entry_t next_out_entry;
	logic pop;
	logic push;
	logic wr_en;
	logic [alm_pkg::PTR_W-1:0] wr_idx;
	logic [alm_pkg::CNT_W-1:0] base_count;
	logic [alm_pkg::PTR_W-1:0] base_tail;
	logic disc_pin_high;

	alm_sync2 u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pin_async(disc_ctl_pin),
		.pin_sync(disc_pin_high)
	);

	alm_stage_ctl u_stage (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.cfg(mute_cfg),
		.disc_pin_high(disc_pin_high),
		.stage(stage)
	);

	assign log_full = (unread_count == alm_pkg::LOG_FULL_CNT);
	assign read_busy = (state == alm_pkg::ALM_SEND);

	always_comb begin
		next_state = state;
		next_head = head;
		next_tail = tail;
		next_count = unread_count;
		next_left = left;
		next_overflow = log_overflow;
		// a frozen enable holds the readout pulse too
		next_out_valid = out_valid;
		next_out_last = out_last;
		next_out_entry = out_entry;
		pop = 1'b0;
		push = 1'b0;
		wr_en = 1'b0;
		wr_idx = tail;
		base_count = unread_count;
		base_tail = tail;
		if (clk_en) begin
			next_out_valid = 1'b0;
			next_out_last = 1'b0;
			if (cmd_clear_log) begin
				// count and pointer back to start
				next_head = alm_pkg::PTR_RST;
				base_tail = alm_pkg::PTR_RST;
				base_count = alm_pkg::CNT_RST;
				next_left = alm_pkg::LEFT_RST;
				next_state = alm_pkg::ALM_IDLE;
				next_overflow = 1'b0;
			end else if (cmd_init_ptr) begin
				// abort any burst, pointer back to oldest entry
				next_left = alm_pkg::LEFT_RST;
				next_state = alm_pkg::ALM_IDLE;
			end else begin
				case (state)
					alm_pkg::ALM_IDLE: begin
						// empty log answers a read with nothing
						if (cmd_read_next && unread_count != alm_pkg::CNT_RST) begin
							next_state = alm_pkg::ALM_SEND;
							next_left = alm_pkg::READ_BURST;
						end
					end
					alm_pkg::ALM_SEND: begin
						pop = 1'b1;
						next_out_valid = 1'b1;
						next_out_entry = log_mem[head];
						next_head = head + alm_pkg::PTR_ONE;
						base_count = unread_count - 6'h01;
						next_left = left - 3'h1;
						if (left == 3'h1 || unread_count == 6'h01) begin
							next_out_last = 1'b1;
							next_left = alm_pkg::LEFT_RST;
							next_state = alm_pkg::ALM_IDLE;
						end
					end
					default: begin
						next_state = alm_pkg::ALM_IDLE;
						next_left = alm_pkg::LEFT_RST;
					end
				endcase
			end
			// a clear or a pop in the same cycle makes room for the arrival
			if (alarm_valid) begin
				if (base_count != alm_pkg::LOG_FULL_CNT) begin
					push = 1'b1;
				end else begin
					// reached only without a clear in the same cycle, since the clear empties the log first
					next_overflow = 1'b1;
				end
			end
			// append at the tail with its stamp
			wr_en = push;
			wr_idx = base_tail;
			next_tail = push ? base_tail + alm_pkg::PTR_ONE : base_tail;
			next_count = push ? base_count + 6'h01 : base_count;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= alm_pkg::ALM_IDLE;
			head <= alm_pkg::PTR_RST;
			tail <= alm_pkg::PTR_RST;
			unread_count <= alm_pkg::CNT_RST;
			left <= alm_pkg::LEFT_RST;
			log_overflow <= 1'b0;
			out_valid <= 1'b0;
			out_last <= 1'b0;
			out_entry <= alm_pkg::ENTRY_RST;
		end else begin
			state <= next_state;
			head <= next_head;
			tail <= next_tail;
			unread_count <= next_count;
			left <= next_left;
			log_overflow <= next_overflow;
			out_valid <= next_out_valid;
			out_last <= next_out_last;
			out_entry <= next_out_entry;
		end
	end

	// storage has no reset; entries are only read below the count
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			log_mem[wr_idx] <= '{stamp: now_stamp, code: alarm_code};
		end
	end

	// helper: entries handed out in the current burst
	logic [2:0] burst_seen;
	logic [2:0] next_burst_seen;

	always_comb begin
		next_burst_seen = burst_seen;
		if (clk_en && out_valid) begin
			next_burst_seen = out_last ? 3'h0 : burst_seen + 3'h1;
		end
		if (clk_en && (cmd_clear_log || cmd_init_ptr)) begin
			next_burst_seen = 3'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_seen <= 3'h0;
		end else begin
			burst_seen <= next_burst_seen;
		end
	end

	sequence read_start_s;
		clk_en && state == alm_pkg::ALM_IDLE && cmd_read_next && !cmd_clear_log
		&& !cmd_init_ptr && unread_count >= 6'h05 && !alarm_valid;
	endsequence

	// fourth entry, then the fifth marked last after four counted
	sequence five_out_s;
		(out_valid && !out_last) ##1 (out_valid && out_last && burst_seen == 3'h4);
	endsequence

	// a log of five or more entries gives a burst of exactly five
	burst_of_five_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		read_start_s ##1 (clk_en && !cmd_clear_log && !cmd_init_ptr) [*5] |-> five_out_s)
		else $error("read-next did not hand out five entries");

	// never more than five per burst
	burst_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		out_valid |-> burst_seen < 3'h5)
		else $error("burst longer than five entries");

	fifo_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pop |=> out_entry == $past(log_mem[head]))
		else $error("entry left out of arrival order");

	read_deletes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pop && !alarm_valid |=> out_valid && unread_count == $past(unread_count) - 6'h01
		&& head == $past(head) + alm_pkg::PTR_ONE)
		else $error("read entry not removed from log");

	count_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		unread_count <= alm_pkg::LOG_FULL_CNT
		&& unread_count[alm_pkg::PTR_W-1:0] == tail - head)
		else $error("unread count out of range");

	empty_silent_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && unread_count == 6'h00 && state == alm_pkg::ALM_IDLE |=> ##1 !out_valid)
		else $error("entry handed out from empty log");

	clear_empties_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cmd_clear_log && !alarm_valid |=> unread_count == 6'h00 && !read_busy)
		else $error("clear left entries behind");

	clear_ptrs_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cmd_clear_log |=> head == alm_pkg::PTR_RST && !log_overflow
		&& unread_count == {5'h00, $past(alarm_valid)})
		else $error("clear did not restore pointers");

	init_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && cmd_init_ptr && !cmd_clear_log |=> state == alm_pkg::ALM_IDLE
		&& head == $past(head) ##1 !out_valid)
		else $error("pointer initialize did not restart readout");
endmodule

// ===== tb/alm_mgr_model.sv
// remote manager model: request pulses, settings and discrete pin
`timescale 1ns/100ps
module alm_mgr_model (
	// clock
	input wire logic sys_clk,
	// requests and settings
	output logic cmd_read_next,
	output logic cmd_clear_log,
	output logic cmd_init_ptr,
	output alm_pkg::alm_mute_cfg_t mute_cfg,
	output logic disc_ctl_pin
);
	initial begin
		cmd_read_next = 1'b0;
		cmd_clear_log = 1'b0;
		cmd_init_ptr = 1'b0;
		mute_cfg = 10'h100;
		disc_ctl_pin = 1'b1;
	end

	// one-cycle request: 0 read-next, 1 clear, 2 init pointer
	task automatic pulse(input logic [1:0] which);
		@(posedge sys_clk);
		#1;
		cmd_read_next = (which == 2'h0);
		cmd_clear_log = (which == 2'h1);
		cmd_init_ptr = (which == 2'h2);
		@(posedge sys_clk);
		#1;
		cmd_read_next = 1'b0;
		cmd_clear_log = 1'b0;
		cmd_init_ptr = 1'b0;
	endtask

	task automatic setup(input alm_pkg::alm_mute_cfg_t cfg, input logic pin);
		@(posedge sys_clk);
		#1;
		mute_cfg = cfg;
		disc_ctl_pin = pin;
	endtask
endmodule

// ===== tb/alm_ctl_tb_top.sv
// self-checking bench for the alarm log and mute controller
`timescale 1ns/100ps
module alm_ctl_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic alarm_valid = 1'b0;
	logic [7:0] alarm_code = 8'h00;
	alm_pkg::alm_stamp_t now_stamp = '0;
	logic cmd_read_next, cmd_clear_log, cmd_init_ptr, disc_ctl_pin;
	alm_pkg::alm_mute_cfg_t mute_cfg, cfg;
	logic out_valid, out_last, log_full, log_overflow, read_busy, pin;
	alm_pkg::alm_entry_t out_entry;
	logic [alm_pkg::CNT_W-1:0] unread_count;
	alm_pkg::alm_stage_t stage, held;
	alm_pkg::alm_entry_t exp_q[$];
	integer seed = 65394;
	int num_errors = 0;
	int total_checks = 0;
	int n_out = 0;

	always #2.5 sys_clk = ~sys_clk;

	alm_mgr_model mgr (.sys_clk(sys_clk), .cmd_read_next(cmd_read_next),
		.cmd_clear_log(cmd_clear_log), .cmd_init_ptr(cmd_init_ptr),
		.mute_cfg(mute_cfg), .disc_ctl_pin(disc_ctl_pin));

	alm_ctl dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.alarm_valid(alarm_valid), .alarm_code(alarm_code), .now_stamp(now_stamp),
		.cmd_read_next(cmd_read_next), .cmd_clear_log(cmd_clear_log),
		.cmd_init_ptr(cmd_init_ptr), .mute_cfg(mute_cfg), .disc_ctl_pin(disc_ctl_pin),
		.out_valid(out_valid), .out_entry(out_entry), .out_last(out_last),
		.unread_count(unread_count), .log_full(log_full), .log_overflow(log_overflow),
		.read_busy(read_busy), .stage(stage));

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic alm_pkg::alm_stage_t exp_stage(input alm_pkg::alm_mute_cfg_t c,
		input logic p);
		alm_pkg::alm_stage_t s;
		s.muted = c.software_mute_ctl | (c.discrete_mute_mode & p);
		s.low_stage_en = !s.muted;
		s.high_stage_en = !(c.software_mute_ctl & !c.bias_enable_ctl);
		s.atten_code = (c.gain_reduction_ctl > alm_pkg::ATTEN_MAX) ? alm_pkg::ATTEN_MAX
			: c.gain_reduction_ctl;
		return s;
	endfunction

	// every entry handed out is compared with the oldest one expected
	always begin
		@(posedge sys_clk);
		#1.5;
		if (out_valid === 1'b1) begin
			n_out++;
			chk("out_entry", out_entry, exp_q.size() ? exp_q.pop_front() : '1);
		end
	end

	// back-to-back alarms; the log model drops those beyond capacity
	task automatic put_alarm(input int n);
		alm_pkg::alm_entry_t e;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			#1;
			e = 56'({$random(seed), $random(seed)});
			alarm_valid = 1'b1;
			alarm_code = e.code;
			now_stamp = e.stamp;
			if (exp_q.size() < alm_pkg::LOG_DEPTH) exp_q.push_back(e);
		end
		@(posedge sys_clk);
		#1;
		alarm_valid = 1'b0;
	endtask

	task automatic read_burst();
		int k;
		int want;
		want = (exp_q.size() < 5) ? exp_q.size() : 5;
		n_out = 0;
		k = 0;
		mgr.pulse(2'h0);
		// an empty log answers with nothing, so there is no last entry to wait for
		while (want > 0 && out_last !== 1'b1 && k < 30) begin
			@(posedge sys_clk);
			#2;
			k++;
		end
		if (k == 30) begin
			num_errors++;
			results();
		end
		@(posedge sys_clk);
		#2;
		chk("burst length", n_out, want);
		chk("unread_count", unread_count, exp_q.size());
		chk("read_busy", read_busy, 1'b0);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		chk("reset count", unread_count, 6'h00);
		chk("reset stage", stage, alm_pkg::STAGE_RST);
		#1;
		rst_n = 1'b1;
		put_alarm(7);
		chk("count after 7", unread_count, 6'h07);
		read_burst();
		read_burst();
		$display("test readout done");
		n_out = 0;
		mgr.pulse(2'h0);
		repeat (5) @(posedge sys_clk);
		#2;
		chk("empty read", n_out, 0);
		put_alarm(33);
		chk("full count", unread_count, alm_pkg::LOG_FULL_CNT);
		chk("log_full", log_full, 1'b1);
		chk("log_overflow", log_overflow, 1'b1);
		mgr.pulse(2'h1);
		exp_q.delete();
		chk("cleared count", unread_count, 6'h00);
		chk("cleared overflow", log_overflow, 1'b0);
		read_burst();
		$display("test clear done");
		put_alarm(6);
		mgr.pulse(2'h0);
		mgr.pulse(2'h2);
		@(posedge sys_clk);
		#2;
		chk("init busy", read_busy, 1'b0);
		chk("init count", unread_count, exp_q.size());
		read_burst();
		if (exp_q.size() > 0) read_burst();
		$display("test pointer done");
		// all mute combinations first, then random settings with clamp corners
		for (int i = 0; i < 24; i++) begin
			cfg = 10'($random(seed));
			pin = 1'($random(seed));
			if (i < 16) begin
				{cfg.software_mute_ctl, cfg.bias_enable_ctl, cfg.discrete_mute_mode, pin} = 4'(i);
			end
			if (i == 16) cfg.gain_reduction_ctl = 7'h78;
			if (i == 17) cfg.gain_reduction_ctl = 7'h79;
			if (i == 18) cfg.gain_reduction_ctl = 7'h7f;
			mgr.setup(cfg, pin);
			repeat (4) @(posedge sys_clk);
			#2;
			chk("stage", stage, exp_stage(cfg, pin));
		end
		$display("test stage done");
		// enable low: an arriving alarm is never logged and new settings wait for the enable
		held = exp_stage(cfg, pin);
		cfg = 10'h200;
		pin = 1'b1;
		@(posedge sys_clk);
		#1;
		clk_en = 1'b0;
		alarm_valid = 1'b1;
		mgr.setup(cfg, pin);
		repeat (4) @(posedge sys_clk);
		#2;
		chk("frozen count", unread_count, exp_q.size());
		chk("frozen stage", stage, held);
		@(posedge sys_clk);
		#1;
		clk_en = 1'b1;
		alarm_valid = 1'b0;
		repeat (4) @(posedge sys_clk);
		#2;
		chk("thawed count", unread_count, exp_q.size());
		chk("thawed stage", stage, exp_stage(cfg, pin));
		$display("test freeze done");
		results();
	end
endmodule
